// ---- rtl/uesh_map.vh ----
// Register offsets, field positions and reset values of the endpoint status block
`ifndef UESH_MAP_VH
`define UESH_MAP_VH
// ==========================================
// Register offsets
`define UESH_OFS_EP_SELECT   8'hC7
`define UESH_OFS_EP_STATUS   8'hCE
`define UESH_OFS_EP_CONTROL  8'hD4
`define UESH_OFS_INT_FLAGS   8'hF8
`define UESH_OFS_INT_MASK    8'hF9
// ==========================================
// Status field positions
`define UESH_ST_DIR          7
`define UESH_ST_OUTB1        6
`define UESH_ST_STALL_REQUEST_FLAG      5
`define UESH_ST_INRDY        4
`define UESH_ST_STLCRC       3
`define UESH_ST_SETUP        2
`define UESH_ST_OUTB0        1
`define UESH_ST_INCMP        0
// ==========================================
// Control field positions and reset values
`define UESH_CT_EN           7
`define UESH_CT_DIR          2
`define UESH_CT_TYPE_HI      1
`define UESH_CT_TYPE_LO      0
`define UESH_CT_RST_EP0      8'h80
`define UESH_CT_RST_OTHER    8'h00
`define UESH_TYPE_CTRL       2'h0
`define UESH_TYPE_ISO        2'h1
// ==========================================
// Handshake codes toward the serial engine
`define UESH_HS_ACK          2'h0
`define UESH_HS_NAK          2'h1
`define UESH_HS_STALL        2'h2
`endif

// ---- rtl/uesh_ep_regs.v ----
// Small per-endpoint register memory with registered read data
`include "uesh_map.vh"
`timescale 1ns/1ps
`default_nettype none
module uesh_ep_regs #(
	parameter NUM_EP = 7,
	parameter AW     = 3
) (
	// Clock and control
	input  wire          mclk_i,
	input  wire          rst_n_i,
	input  wire          ce_i,
	// Write port
	input  wire          we_i,
	input  wire [AW-1:0] waddr_i,
	input  wire [7:0]    wdata_i,
	// Read port
	input  wire [AW-1:0] raddr_i,
	output reg  [7:0]    rdata_o
);
	reg [7:0] mem_r [0:NUM_EP-1];
	integer k;
	// ==========================================
	// Storage; endpoint zero resets enabled as control
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			for (k = 0; k < NUM_EP; k = k + 1) begin
				mem_r[k] <= (k == 0) ? `UESH_CT_RST_EP0 : `UESH_CT_RST_OTHER;
			end
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			if (we_i) begin
				mem_r[waddr_i] <= wdata_i;
			end
			rdata_o <= mem_r[raddr_i];
		end
	end
endmodule
`default_nettype wire

// ---- rtl/uesh_top.v ----
// Endpoint status and handshake logic of a full-speed device controller
// Structure
// The firmware side sees five byte registers: endpoint select, the status
// and control bytes of the selected endpoint, the interrupt flags and the
// interrupt mask. Control bytes sit in a small memory with a registered
// read port; a shadow copy per endpoint feeds the serial side, so both
// sides may look at different endpoints in the same cycle.
// Status bytes are plain flops because hardware and firmware both write
// them; a hardware set always beats a firmware clear in the same cycle,
// so firmware never loses an event it has not yet seen.
// The serial answers are combinational from the status of the endpoint
// the serial engine names, which keeps the handshake decision inside one
// cycle. Endpoint numbers above the last endpoint are not decoded: the
// select register accepts them, but status and control accesses are then
// ignored and read zero.
// The clock enable freezes every flop, including the read data register.
//
// Our own choice: the plain strobed port.
`include "uesh_map.vh"
`timescale 1ns/1ps
`default_nettype none
module uesh_top #(
	parameter NUM_EP = 7
) (
	// Clock, reset, enable
	input  wire       mclk_i,
	input  wire       rst_n_i,
	input  wire       ce_i,
	// Register port
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output reg  [7:0] reg_rdata_o,
	// Serial engine events
	input  wire [2:0] sie_ep_i,
	input  wire       sie_in_token_i,
	input  wire       sie_in_sent_i,
	input  wire       sie_in_acked_i,
	input  wire       sie_out_b0_i,
	input  wire       sie_out_b1_i,
	input  wire       sie_setup_i,
	input  wire       sie_stlcrc_i,
	input  wire       sie_dir_in_i,
	input  wire       sie_fifo_empty_i,
	// Serial engine answers
	output wire [1:0] sie_handshake_o,
	output wire       sie_in_send_o,
	output wire       sie_zero_len_o,
	output wire       sie_out_b1_accept_o,
	// Interrupt
	output wire       irq_o
);
	// ==========================================
	// State
	reg  [3:0]        ep_select_r;
	reg  [7:0]        status_r [0:NUM_EP-1];
	reg  [NUM_EP-1:0] int_flags_r;
	reg  [NUM_EP-1:0] int_mask_r;
	reg  [7:0]        ctrl_sie_r [0:NUM_EP-1];
	reg               rd_ctrl_r;
	reg  [7:0]        rd_data_r;
	wire [7:0]        ctrl_rdata;
	wire [2:0]        sel = ep_select_r[2:0];
	wire [NUM_EP-1:0] int_flags_nxt;
	integer           k_sh;
	integer           k_st;

	// ==========================================
	// Decode helpers
	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	function is_pingpong;
		input [2:0] ep;
		begin
			is_pingpong = (ep >= 3'h4) && (ep <= 3'h6);
		end
	endfunction

	wire sel_ok = (ep_select_r < NUM_EP);
	wire wr_ctl = reg_wr_i && hit(reg_addr_i, `UESH_OFS_EP_CONTROL) && sel_ok;
	wire wr_st  = reg_wr_i && hit(reg_addr_i, `UESH_OFS_EP_STATUS) && sel_ok;
	wire rd_st  = reg_rd_i && hit(reg_addr_i, `UESH_OFS_EP_STATUS) && sel_ok;
	wire rd_int = reg_rd_i && hit(reg_addr_i, `UESH_OFS_INT_FLAGS);

	// ==========================================
	// Control registers live in a small memory
	uesh_ep_regs #(.NUM_EP(NUM_EP), .AW(3)) u_regs (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.we_i    (wr_ctl),
		.waddr_i (sel),
		.wdata_i (reg_wdata_i),
		.raddr_i (sel),
		.rdata_o (ctrl_rdata)
	);

	// Shadow of the control type and enable for the serial side, one per endpoint
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			for (k_sh = 0; k_sh < NUM_EP; k_sh = k_sh + 1) begin
				ctrl_sie_r[k_sh] <= (k_sh == 0) ? `UESH_CT_RST_EP0 : `UESH_CT_RST_OTHER;
			end
		end else if (ce_i && wr_ctl) begin
			ctrl_sie_r[sel] <= reg_wdata_i;
		end
	end

	wire [7:0] sie_ctl = ctrl_sie_r[sie_ep_i];
	wire [1:0] sie_type = sie_ctl[`UESH_CT_TYPE_HI:`UESH_CT_TYPE_LO];
	wire       sie_iso = (sie_type == `UESH_TYPE_ISO);
	wire [7:0] sie_st = status_r[sie_ep_i];

	// ==========================================
	// Handshake answers; stall wins over everything
	assign sie_handshake_o = sie_st[`UESH_ST_STALL_REQUEST_FLAG] ? `UESH_HS_STALL :
		(sie_in_token_i && !sie_st[`UESH_ST_INRDY]) ? `UESH_HS_NAK :
		`UESH_HS_ACK;
	assign sie_in_send_o  = sie_in_token_i && sie_st[`UESH_ST_INRDY] &&
		!sie_st[`UESH_ST_STALL_REQUEST_FLAG];
	assign sie_zero_len_o = sie_in_send_o && sie_fifo_empty_i;
	// Bank 1 stays closed until firmware clears its flag, iso never blocks
	assign sie_out_b1_accept_o = !sie_st[`UESH_ST_OUTB1] || sie_iso;

	// ==========================================
	// Status flags; hardware set wins over firmware clear
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			for (k_st = 0; k_st < NUM_EP; k_st = k_st + 1) begin
				status_r[k_st] <= 8'h00;
			end
		end else if (ce_i) begin
			for (k_st = 0; k_st < NUM_EP; k_st = k_st + 1) begin
				// Firmware write first, then hardware events override
				if (wr_st && sel == k_st) begin
					status_r[k_st] <= reg_wdata_i;
				end
				if (sie_ep_i == k_st) begin
					if (sie_out_b1_i && is_pingpong(k_st[2:0]) &&
						sie_out_b1_accept_o) begin
						status_r[k_st][`UESH_ST_OUTB1] <= 1'b1;
					end
					if (sie_out_b0_i) begin
						status_r[k_st][`UESH_ST_OUTB0] <= 1'b1;
					end
					if (sie_setup_i) begin
						status_r[k_st][`UESH_ST_SETUP] <= 1'b1;
						// Direction only tracked on control endpoints
						if (sie_type == `UESH_TYPE_CTRL) begin
							status_r[k_st][`UESH_ST_DIR] <= sie_dir_in_i;
						end
					end
					if (sie_stlcrc_i) begin
						status_r[k_st][`UESH_ST_STLCRC] <= 1'b1;
					end
					// In ready clears on send for iso, on ack otherwise
					if (sie_st[`UESH_ST_INRDY] &&
						((sie_iso && sie_in_sent_i) ||
						(!sie_iso && sie_in_acked_i))) begin
						status_r[k_st][`UESH_ST_INRDY]  <= 1'b0;
						status_r[k_st][`UESH_ST_INCMP] <= 1'b1;
					end
				end
			end
		end
	end

	// Event pulse per endpoint: any hardware set of a status flag
	wire hw_clr_in = sie_st[`UESH_ST_INRDY] &&
		((sie_iso && sie_in_sent_i) || (!sie_iso && sie_in_acked_i));
	wire b1_set = sie_out_b1_i && is_pingpong(sie_ep_i) && sie_out_b1_accept_o;
	wire ev_any = hw_clr_in || b1_set || sie_out_b0_i || sie_setup_i || sie_stlcrc_i;

	// ==========================================
	// Interrupt mask, one enable bit per endpoint
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			int_mask_r <= {NUM_EP{1'b0}};
		end else if (ce_i && reg_wr_i && hit(reg_addr_i, `UESH_OFS_INT_MASK)) begin
			int_mask_r <= reg_wdata_i[NUM_EP-1:0];
		end
	end

	// Next flag value per endpoint; a new event beats the clearing read
	// so an event that lands during the read is never lost
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g = g + 1) begin : g_iflag
			assign int_flags_nxt[g] = (ev_any && (sie_ep_i == g)) ? 1'b1 :
				rd_int ? 1'b0 : int_flags_r[g];
		end
	endgenerate

	// Interrupt flags, cleared by reading them
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			int_flags_r <= {NUM_EP{1'b0}};
		end else if (ce_i) begin
			int_flags_r <= int_flags_nxt;
		end
	end

	assign irq_o = |(int_flags_r & int_mask_r);

	// ==========================================
	// Read data, one cycle after the strobe
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rd_ctrl_r <= 1'b0;
			rd_data_r <= 8'h00;
		end else if (ce_i) begin
			rd_ctrl_r <= reg_rd_i && hit(reg_addr_i, `UESH_OFS_EP_CONTROL) && sel_ok;
			if (reg_rd_i) begin
				if (rd_st) begin
					rd_data_r <= status_r[sel];
				end else if (hit(reg_addr_i, `UESH_OFS_EP_SELECT)) begin
					rd_data_r <= {4'h0, ep_select_r};
				end else if (rd_int) begin
					rd_data_r <= {{(8-NUM_EP){1'b0}}, int_flags_r};
				end else if (hit(reg_addr_i, `UESH_OFS_INT_MASK)) begin
					rd_data_r <= {{(8-NUM_EP){1'b0}}, int_mask_r};
				end else begin
					rd_data_r <= 8'h00;
				end
			end
		end
	end

	always @* begin
		reg_rdata_o = rd_ctrl_r ? ctrl_rdata : rd_data_r;
	end

	// ==========================================
	// Endpoint select register
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ep_select_r <= 4'h0;
		end else if (ce_i && reg_wr_i && hit(reg_addr_i, `UESH_OFS_EP_SELECT)) begin
			ep_select_r <= reg_wdata_i[3:0];
		end
	end
endmodule
`default_nettype wire

// ---- dv/uesh_asserts.sv ----
// Port checker of the endpoint status block
`timescale 1ns/1ps
`default_nettype none
module uesh_chk (
	input wire logic       mclk_i, rst_n_i, ce_i, reg_wr_i, reg_rd_i,
	input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
	input wire logic [2:0] sie_ep_i,
	input wire logic       sie_setup_i, sie_out_b1_i, sie_fifo_empty_i,
	input wire logic       sie_in_send_o, sie_zero_len_o, irq_o
);
	logic [7:0] sel_r;
	logic [7:0] mask_r;
	logic       fresh_r;
	wire        hit = ce_i && ({1'b0, sie_ep_i} == sel_r[3:0]);
	wire        rd_st = ce_i && reg_rd_i && (reg_addr_i == 8'hCE);
	// ========
	// Shadow of select and mask; fresh until firmware first writes
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sel_r <= 8'h00;
			mask_r <= 8'h00;
			fresh_r <= 1'h1;
		end else if (ce_i && reg_wr_i) begin
			fresh_r <= 1'h0;
			if (reg_addr_i == 8'hC7) sel_r <= reg_wdata_i;
			if (reg_addr_i == 8'hF9) mask_r <= reg_wdata_i;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// Event on the selected endpoint, then a status read with no write between
	sequence s_rd(ev);
		ev && hit && !reg_wr_i ##1 !reg_wr_i ##1 rd_st;
	endsequence
	a_setup_flag: assert property (s_rd(sie_setup_i) |=> reg_rdata_o[2])
		else $error("setup flag missing");
	a_bank1_flag: assert property (s_rd(sie_out_b1_i && sie_ep_i >= 3'h4 && sie_ep_i <= 3'h6)
		|=> reg_rdata_o[6])
		else $error("bank one flag missing");
	a_ctrl_reset: assert property (fresh_r && ce_i && reg_rd_i && reg_addr_i == 8'hD4
		|=> reg_rdata_o == 8'h80) else $error("control reset value wrong");
	a_unmapped_read: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h00
		|=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_select_range: assert property (rd_st && sel_r[3:0] >= 4'h7 |=> reg_rdata_o == 8'h00)
		else $error("status of absent endpoint not zero");
	a_mask_quiet: assert property (mask_r == 8'h00 |-> !irq_o)
		else $error("interrupt while fully masked");
	a_irq_raise: assert property (sie_setup_i && ce_i && mask_r[sie_ep_i] && !reg_wr_i
		|-> ##[1:2] irq_o) else $error("enabled interrupt not raised");
	a_zero_len: assert property (sie_in_send_o && sie_fifo_empty_i |-> sie_zero_len_o)
		else $error("empty send without zero length");
endmodule
bind uesh_top uesh_chk i_chk (.*);
`default_nettype wire

// ---- dv/uesh_host_model.sv ----
// Behavioural serial engine and host side of the endpoint block
`timescale 1ns/1ps
`default_nettype none
module uesh_host_model (
	// Clock
	input  wire logic       mclk_i,
	// Events toward the block: sent, acked, bank0, bank1, setup, stall/crc
	output var  logic [2:0] ep_o,
	output var  logic [5:0] ev_o,
	output var  logic       tok_o,
	output var  logic       empty_o,
	output var  logic       dir_o
);
	// Idle bus; FIFO never loaded, so ready always means a zero length packet
	initial begin
		ep_o = 3'h0;
		ev_o = 6'h00;
		tok_o = 1'h0;
		empty_o = 1'h1;
		dir_o = 1'h0;
	end
	// Direction level latched by the block on the next setup of a control endpoint
	task set_dir(input logic d);
		@(posedge mclk_i);
		dir_o <= d;
	endtask
	// One event pulse; endpoint and token stay after it
	task pulse(input logic [2:0] ep, input logic tok, input logic [5:0] ev);
		@(posedge mclk_i);
		ep_o <= ep;
		tok_o <= tok;
		ev_o <= ev;
		@(posedge mclk_i);
		ev_o <= 6'h00;
	endtask
endmodule
`default_nettype wire

// ---- dv/tb_usb_endpoint_status_handshake.sv ----
// Self-checking bench of the endpoint status block
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_status_handshake;
	logic       mclk_i, rst_n_i, wr, rd, ce;
	logic [7:0] addr, wdata;
	wire  [7:0] rdata;
	wire  [1:0] hs;
	wire  [2:0] ep;
	wire  [5:0] ev;
	wire        tok, empty, dir, send, zlp, b1ok, irq;
	int         err_count, total_checks;
	uesh_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.sie_ep_i(ep), .sie_in_token_i(tok), .sie_in_sent_i(ev[0]), .sie_in_acked_i(ev[1]),
		.sie_out_b0_i(ev[2]), .sie_out_b1_i(ev[3]), .sie_setup_i(ev[4]), .sie_stlcrc_i(ev[5]),
		.sie_dir_in_i(dir), .sie_fifo_empty_i(empty), .sie_handshake_o(hs),
		.sie_in_send_o(send), .sie_zero_len_o(zlp), .sie_out_b1_accept_o(b1ok), .irq_o(irq));
	uesh_host_model i_host (.mclk_i(mclk_i), .ep_o(ep), .ev_o(ev), .tok_o(tok),
		.empty_o(empty), .dir_o(dir));
	// ========
	// Clock and watchdog; the run needs little over a hundred cycles
	initial begin
		mclk_i = 1'h0;
		forever #2 mclk_i = ~mclk_i;
	end
	initial begin
		#20000;
		err_count++;
		finish_test();
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask
	task wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge mclk_i);
		wr <= 1'h0;
	endtask
	// Read data stand from the cycle after the strobe; control data only in that cycle
	task rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'h1;
		@(posedge mclk_i);
		rd <= 1'h0;
		#1 chk($sformatf("register %h", a), e, rdata);
	endtask
	// ========
	// Scenarios
	task t_reset;
		rdc(8'hD4, 8'h80);
		wrr(8'hC7, 8'h05);
		rdc(8'hD4, 8'h00);
		rdc(8'h00, 8'h00);
		wrr(8'hC7, 8'h07);
		rdc(8'hCE, 8'h00);
		wrr(8'hF9, 8'h13);
	endtask
	task t_setup;
		wrr(8'hC7, 8'h00);
		i_host.pulse(3'h0, 1'h0, 6'h10);
		rdc(8'hCE, 8'h04);
		chk("irq", 8'h01, {7'h00, irq});
		rdc(8'hF8, 8'h01);
		chk("irq", 8'h00, {7'h00, irq});
	endtask
	task t_stall;
		wrr(8'hC7, 8'h02);
		wrr(8'hCE, 8'h20);
		i_host.pulse(3'h2, 1'h1, 6'h00);
		#1 chk("handshake", 8'h02, {6'h00, hs});
		rdc(8'hCE, 8'h20);
	endtask
	task t_bulk;
		wrr(8'hC7, 8'h01);
		wrr(8'hD4, 8'h82);
		wrr(8'hCE, 8'h10);
		i_host.pulse(3'h1, 1'h1, 6'h01);
		rdc(8'hCE, 8'h10);
		i_host.pulse(3'h1, 1'h1, 6'h02);
		rdc(8'hCE, 8'h01);
		chk("irq", 8'h01, {7'h00, irq});
		rdc(8'hF8, 8'h02);
	endtask
	task t_iso;
		wrr(8'hC7, 8'h03);
		wrr(8'hD4, 8'h81);
		wrr(8'hCE, 8'h10);
		i_host.pulse(3'h3, 1'h1, 6'h00);
		#1 chk("send", 8'h01, {7'h00, send});
		chk("zero length", 8'h01, {7'h00, zlp});
		i_host.pulse(3'h3, 1'h1, 6'h01);
		rdc(8'hCE, 8'h01);
	endtask
	task t_bank1;
		wrr(8'hC7, 8'h04);
		wrr(8'hD4, 8'h82);
		i_host.pulse(3'h4, 1'h0, 6'h08);
		#1 chk("bank one accept", 8'h00, {7'h00, b1ok});
		rdc(8'hCE, 8'h40);
		chk("irq", 8'h01, {7'h00, irq});
		rdc(8'hF8, 8'h18);
		wrr(8'hC7, 8'h05);
		wrr(8'hD4, 8'h81);
		i_host.pulse(3'h5, 1'h0, 6'h08);
		#1 chk("bank one accept", 8'h01, {7'h00, b1ok});
	endtask
	// Clock enable low: writes and events are both ignored
	task t_freeze;
		@(posedge mclk_i);
		ce <= 1'h0;
		wrr(8'hC7, 8'h06);
		i_host.pulse(3'h5, 1'h0, 6'h04);
		@(posedge mclk_i);
		ce <= 1'h1;
		rdc(8'hC7, 8'h05);
		rdc(8'hCE, 8'h40);
	endtask
	// Direction latched on setup only for a control endpoint
	task t_dir;
		wrr(8'hC7, 8'h00);
		i_host.set_dir(1'h1);
		i_host.pulse(3'h0, 1'h0, 6'h10);
		rdc(8'hCE, 8'h84);
		wrr(8'hC7, 8'h01);
		i_host.pulse(3'h1, 1'h0, 6'h10);
		rdc(8'hCE, 8'h05);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ========
	// Reset for ten cycles, then the scenarios
	initial begin
		rst_n_i = 1'h0;
		wr = 1'h0;
		rd = 1'h0;
		ce = 1'h1;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (10) @(posedge mclk_i);
		rst_n_i <= 1'h1;
		t_reset();
		t_setup();
		t_stall();
		t_bulk();
		t_iso();
		t_bank1();
		t_freeze();
		t_dir();
		finish_test();
	end
endmodule
`default_nettype wire
